//--- rtl/usbepc_top.sv
// Endpoint 0 transmit and endpoint 1 control registers with an AHB-Lite slave.
//
// Overview of operation
// - OUT tokens to endpoint 0 are NAKed while its transmit is armed.
// - Endpoint 0 transmit stall bit makes IN tokens on endpoint 0 STALL.
// - Stall bits are set by the engine or by writing one.
// - Endpoint 0 transmit stall clears on SETUP receipt or bus reset.
// - Writing zero to a stall bit has no effect.
// - Bit 0 of endpoint 0 transmit control shows engine transmit enable, read-only.
// - Bit 3 of endpoint 1 receive control shows last received data toggle.
// - Endpoint 1 receive stall bit makes OUT tokens on endpoint 1 STALL.
// - Both endpoint 1 stall bits clear on bus reset or clear-halt for endpoint 1.
// - Endpoint 1 receive enable is a writable bit that gates reception.
// - OUT tokens to endpoint 1 are NAKed while its transfer is pending.
// - Endpoint 1 transmit stall bit makes IN tokens on endpoint 1 STALL.
// - Bit 0 of endpoint 1 transmit control shows engine transmit enable, read-only.
// - Reserved bits of the three registers read as zero.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "usbepc_cfg.svh"
module usbepc_top (
    input  wire logic        ref_clk,          // Processor clock, 40 MHz.
    input  wire logic        rst_n,            // Synchronous reset, active low.
    input  wire logic        hsel,             // AHB slave select.
    input  wire logic [31:0] haddr,            // AHB address.
    input  wire logic [1:0]  htrans,           // AHB transfer type.
    input  wire logic        hwrite,           // AHB write strobe.
    input  wire logic [2:0]  hsize,            // AHB transfer size.
    input  wire logic [31:0] hwdata,           // AHB write data.
    input  wire logic        hready,           // AHB bus ready.
    output logic [31:0]      hrdata,           // AHB read data.
    output logic             hreadyout,        // AHB slave ready.
    output logic             hresp,            // AHB response, always OKAY.
    input  wire logic        bus_reset,        // USB bus reset seen by the engine.
    input  wire logic        setup_rcvd,       // Pulse: SETUP packet received on endpoint 0.
    input  wire logic        clr_halt_ep1,     // Pulse: clear-feature halt for endpoint 1.
    input  wire logic        set_halt_ep0,     // Pulse: engine sets endpoint 0 transmit stall.
    input  wire logic        set_halt_ep1_rx,  // Pulse: engine sets endpoint 1 receive stall.
    input  wire logic        set_halt_ep1_tx,  // Pulse: engine sets endpoint 1 transmit stall.
    input  wire logic        ep0_tx_done,      // Pulse: endpoint 0 packet sent.
    input  wire logic        ep1_tx_done,      // Pulse: endpoint 1 packet sent.
    input  wire logic        ep0_tx_enabled,   // Engine has endpoint 0 transmit enabled.
    input  wire logic        ep1_tx_enabled,   // Engine has endpoint 1 transmit enabled.
    input  wire logic        ep1_rx_data,      // Pulse: endpoint 1 data packet received.
    input  wire logic        ep1_rx_toggle,    // Toggle of that received packet.
    input  wire logic        out_token,        // Pulse: OUT token decoded.
    input  wire logic        in_token,         // Pulse: IN token decoded.
    input  wire logic [3:0]  token_ep,         // Endpoint number of the token.
    output usbepc_pkg::usbepc_hs_e handshake,  // Handshake choice for the current token.
    output logic             ep0_tx_armed,     // Endpoint 0 packet may be sent.
    output logic             ep1_tx_armed,     // Endpoint 1 packet may be sent.
    output logic             ep1_rx_enable     // Endpoint 1 reception enabled.
);

    logic                     ap_valid;
    logic                     ap_write;
    logic [`USBEPC_ADDR_W-1:0] ap_addr;
    logic                     ep0_stall;
    logic                     ep1_rx_stall;
    logic                     ep1_tx_stall;
    logic                     data_toggle_state;
    logic                     ep1_rx_en_q;
    logic                     next_ep1_rx_en;
    logic                     next_toggle;
    usbepc_pkg::usbepc_reg_t  ep0tx_view;
    usbepc_pkg::usbepc_reg_t  ep1rx_view;
    usbepc_pkg::usbepc_reg_t  ep1tx_view;
    usbepc_pkg::usbepc_reg_t  read_sel;
    usbepc_pkg::usbepc_hs_e   next_hs;

    wire addr_take   = hsel & hready & htrans[1];
    wire wr_active   = ap_valid & ap_write;
    wire hit_ep0tx   = ap_addr == `USBEPC_ADDR_EP0TX;
    wire hit_ep1rx   = ap_addr == `USBEPC_ADDR_EP1RX;
    wire hit_ep1tx   = ap_addr == `USBEPC_ADDR_EP1TX;
    wire wr_ep0tx    = wr_active & hit_ep0tx;
    wire wr_ep1rx    = wr_active & hit_ep1rx;
    wire wr_ep1tx    = wr_active & hit_ep1tx;
    wire w_tx        = hwdata[`USBEPC_BIT_TX];
    wire w_stall     = hwdata[`USBEPC_BIT_STALL];
    wire w_enable    = hwdata[`USBEPC_BIT_ENABLE];
    wire clr_ep0     = setup_rcvd | bus_reset;
    wire clr_ep1     = clr_halt_ep1 | bus_reset;
    wire tok_ep0     = token_ep == 4'h0;
    wire tok_ep1     = token_ep == 4'h1;
    wire rd_ep0tx    = haddr[`USBEPC_ADDR_W-1:0] == `USBEPC_ADDR_EP0TX;
    wire rd_ep1rx    = haddr[`USBEPC_ADDR_W-1:0] == `USBEPC_ADDR_EP1RX;
    wire rd_ep1tx    = haddr[`USBEPC_ADDR_W-1:0] == `USBEPC_ADDR_EP1TX;

    // Address phase is captured; the data phase always completes in one cycle.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= '0;
        end else if (hready) begin
            ap_valid <= addr_take;
            ap_write <= hwrite;
            ap_addr  <= haddr[`USBEPC_ADDR_W-1:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    usbepc_arm_bit u_arm_ep0 (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .bus_reset (bus_reset),
        .sw_set    (wr_ep0tx & w_tx),
        .done      (ep0_tx_done),
        .armed     (ep0_tx_armed)
    );

    usbepc_arm_bit u_arm_ep1 (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .bus_reset (bus_reset),
        .sw_set    (wr_ep1tx & w_tx),
        .done      (ep1_tx_done),
        .armed     (ep1_tx_armed)
    );

    usbepc_stall_bit u_stall_ep0 (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .sw_set  (wr_ep0tx & w_stall),
        .hw_set  (set_halt_ep0),
        .hw_clr  (clr_ep0),
        .stall   (ep0_stall)
    );

    usbepc_stall_bit u_stall_ep1_rx (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .sw_set  (wr_ep1rx & w_stall),
        .hw_set  (set_halt_ep1_rx),
        .hw_clr  (clr_ep1),
        .stall   (ep1_rx_stall)
    );

    usbepc_stall_bit u_stall_ep1_tx (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .sw_set  (wr_ep1tx & w_stall),
        .hw_set  (set_halt_ep1_tx),
        .hw_clr  (clr_ep1),
        .stall   (ep1_tx_stall)
    );

    // Reception enable is purely software owned; bus reset returns it to off.
    assign next_ep1_rx_en = bus_reset ? 1'b0 : (wr_ep1rx ? w_enable : ep1_rx_en_q);
    assign next_toggle    = ep1_rx_data ? ep1_rx_toggle : data_toggle_state;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ep1_rx_en_q       <= 1'b0;
            data_toggle_state <= 1'b0;
        end else begin
            ep1_rx_en_q       <= next_ep1_rx_en;
            data_toggle_state <= next_toggle;
        end
    end

    assign ep1_rx_enable = ep1_rx_en_q;

    // Read views; every reserved position is tied to zero.
    assign ep0tx_view = {3'h0, ep0_tx_armed, 1'b0, ep0_stall, 1'b0, ep0_tx_enabled};
    assign ep1rx_view = {4'h0, data_toggle_state, ep1_rx_stall, 1'b0, ep1_rx_en_q};
    assign ep1tx_view = {3'h0, ep1_tx_armed, 1'b0, ep1_tx_stall, 1'b0, ep1_tx_enabled};

    // Selection decodes the address phase, so the data register is loaded before the data phase.
    assign read_sel = rd_ep0tx ? ep0tx_view :
                      rd_ep1rx ? ep1rx_view :
                      rd_ep1tx ? ep1tx_view : `USBEPC_RESET_VALUE;

    // Read data is registered so it stands through the single data phase.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take & ~hwrite) begin
            hrdata <= {24'h00_0000, read_sel};
        end
    end

    // Stall outranks the pending-transmit NAK, as a halted pipe must report halt.
    always_comb begin
        next_hs = usbepc_pkg::USBEPC_HS_NONE;
        if (in_token & tok_ep0 & ep0_stall) begin
            next_hs = usbepc_pkg::USBEPC_HS_STALL;
        end else if (in_token & tok_ep1 & ep1_tx_stall) begin
            next_hs = usbepc_pkg::USBEPC_HS_STALL;
        end else if (out_token & tok_ep1 & ep1_rx_stall) begin
            next_hs = usbepc_pkg::USBEPC_HS_STALL;
        end else if (out_token & tok_ep0 & ep0_tx_armed) begin
            next_hs = usbepc_pkg::USBEPC_HS_NAK;
        end else if (out_token & tok_ep1 & (ep1_tx_armed | ~ep1_rx_en_q)) begin
            next_hs = usbepc_pkg::USBEPC_HS_NAK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            handshake <= usbepc_pkg::USBEPC_HS_NONE;
        end else begin
            handshake <= next_hs;
        end
    end

endmodule

//--- rtl/usbepc_cfg.svh
// Register offsets, field positions and reset values of the endpoint control block.
`ifndef USBEPC_CFG_SVH
`define USBEPC_CFG_SVH

// Printed offsets are not multiples of four, so they are register indices.
`define USBEPC_IDX_EP0TX      8'hb1
`define USBEPC_IDX_EP1RX      8'hb2
`define USBEPC_IDX_EP1TX      8'hb3
`define USBEPC_ADDR_EP0TX     10'h2c4
`define USBEPC_ADDR_EP1RX     10'h2c8
`define USBEPC_ADDR_EP1TX     10'h2cc
`define USBEPC_ADDR_W         10

`define USBEPC_BIT_ENABLE     0
`define USBEPC_BIT_STALL      2
`define USBEPC_BIT_TOGGLE     3
`define USBEPC_BIT_TX         4

`define USBEPC_RESET_VALUE    8'h00

`define USBEPC_HTRANS_NONSEQ  2'h2
`define USBEPC_HSIZE_WORD     3'h2

`endif

//--- rtl/usbepc_pkg.sv
// Types shared by the endpoint control block.
package usbepc_pkg;

    typedef enum logic [1:0] {
        USBEPC_HS_NONE  = 2'b00,
        USBEPC_HS_NAK   = 2'b01,
        USBEPC_HS_STALL = 2'b10
    } usbepc_hs_e;

    typedef logic [7:0] usbepc_reg_t;

endpackage

//--- rtl/usbepc_stall_bit.sv
// One stall flag: set by software or engine, cleared only by hardware events.
`timescale 1ns/1ps
module usbepc_stall_bit (
    input  wire logic ref_clk,      // Processor clock.
    input  wire logic rst_n,        // Synchronous reset, active low.
    input  wire logic sw_set,       // Processor wrote one to the flag.
    input  wire logic hw_set,       // Engine sets the flag.
    input  wire logic hw_clr,       // Hardware clear event.
    output logic      stall         // Flag value.
);

    logic next_stall;

    // A write of zero never reaches this module, so software cannot clear it.
    // Engine set outranks a hardware clear, and both outrank a processor write.
    assign next_stall = hw_set ? 1'b1 : (hw_clr ? 1'b0 : (sw_set ? 1'b1 : stall));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stall <= 1'b0;
        end else begin
            stall <= next_stall;
        end
    end

endmodule

//--- rtl/usbepc_arm_bit.sv
// One transmit arm flag: set by software, cleared by the engine on completion.
`timescale 1ns/1ps
module usbepc_arm_bit (
    input  wire logic ref_clk,      // Processor clock.
    input  wire logic rst_n,        // Synchronous reset, active low.
    input  wire logic bus_reset,    // USB bus reset.
    input  wire logic sw_set,       // Processor wrote one to the arm bit.
    input  wire logic done,         // Engine finished the packet.
    output logic      armed         // Arm flag value.
);

    logic next_armed;

    // The engine's completion wins over a write in the same cycle.
    assign next_armed = (done | bus_reset) ? 1'b0 : (sw_set ? 1'b1 : armed);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else begin
            armed <= next_armed;
        end
    end

endmodule

//--- verification/usbepc_host_model.sv
// Host side token source for the endpoint control block.
`timescale 1ns/1ps
module usbepc_host_model (
    input  wire logic       ref_clk,   // Processor clock.
    output logic            out_token, // OUT token pulse.
    output logic            in_token,  // IN token pulse.
    output logic [3:0]      token_ep   // Token endpoint.
);
    initial begin
        out_token = 1'b0;
        in_token = 1'b0;
        token_ep = 4'h5;
    end
    // Between tokens the endpoint field is inverted so nothing may rely on it.
    task automatic send(input logic is_in, input logic [3:0] ep);
        @(posedge ref_clk);
        out_token <= !is_in;
        in_token <= is_in;
        token_ep <= ep;
        @(posedge ref_clk);
        out_token <= 1'b0;
        in_token <= 1'b0;
        token_ep <= ~ep;
    endtask
endmodule

//--- verification/usbepc_top_checker.sv
// Port assertions for the endpoint control block.
`timescale 1ns/1ps
module usbepc_top_checker (
    input wire logic              ref_clk,       // Processor clock.
    input wire logic              rst_n,         // Synchronous reset, active low.
    input wire logic              hsel,          // Slave select.
    input wire logic              hwrite,        // Write strobe.
    input wire logic              hreadyout,     // Slave ready.
    input wire logic              hresp,         // Response.
    input wire logic              bus_reset,     // USB bus reset.
    input wire logic [1:0]        htrans,        // Transfer type.
    input wire logic [31:0]       hrdata,        // Read data.
    input wire logic              ep0_tx_done,   // Endpoint 0 packet sent.
    input wire logic              ep1_tx_done,   // Endpoint 1 packet sent.
    input wire logic              out_token,     // OUT token pulse.
    input wire logic              in_token,      // IN token pulse.
    input wire logic [3:0]        token_ep,      // Token endpoint.
    input usbepc_pkg::usbepc_hs_e handshake,     // Handshake answer.
    input wire logic              ep0_tx_armed,  // Endpoint 0 arm flag.
    input wire logic              ep1_tx_armed,  // Endpoint 1 arm flag.
    input wire logic              ep1_rx_enable  // Endpoint 1 reception enable.
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rsvd; hrdata[31:8] == 24'h0 && hreadyout && !hresp; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read bits set");
    property p_nak0;
        out_token && token_ep == 4'h0 && ep0_tx_armed && !ep0_tx_done
        |=> handshake == usbepc_pkg::USBEPC_HS_NAK;
    endproperty
    a_nak0: assert property (p_nak0) else $error("endpoint 0 OUT not refused");
    property p_nak1;
        out_token && token_ep == 4'h1 && ep1_tx_armed && !ep1_tx_done
        |=> handshake != usbepc_pkg::USBEPC_HS_NONE;
    endproperty
    a_nak1: assert property (p_nak1) else $error("endpoint 1 OUT not refused");
    property p_done0; ep0_tx_done |=> !ep0_tx_armed; endproperty
    a_done0: assert property (p_done0) else $error("endpoint 0 arm kept");
    property p_done1; ep1_tx_done |=> !ep1_tx_armed; endproperty
    a_done1: assert property (p_done1) else $error("endpoint 1 arm kept");
    property p_hold0; ep0_tx_armed && !ep0_tx_done && !bus_reset |=> ep0_tx_armed; endproperty
    a_hold0: assert property (p_hold0) else $error("endpoint 0 arm lost");
    property p_bus; bus_reset |=> !ep0_tx_armed && !ep1_tx_armed && !ep1_rx_enable; endproperty
    a_bus: assert property (p_bus) else $error("bus reset left flags set");
    property p_idle; !out_token && !in_token |=> handshake == usbepc_pkg::USBEPC_HS_NONE; endproperty
    a_idle: assert property (p_idle) else $error("handshake without token");
    property p_rxen;
        $changed(ep1_rx_enable) |-> $past(bus_reset) || $past(hsel && hwrite && htrans[1], 2);
    endproperty
    a_rxen: assert property (p_rxen) else $error("receive enable moved alone");
endmodule
bind usbepc_top usbepc_top_checker i_usbepc_top_checker (.ref_clk, .rst_n, .hsel, .hwrite,
    .hreadyout, .hresp, .bus_reset, .htrans, .hrdata, .ep0_tx_done, .ep1_tx_done, .out_token,
    .in_token, .token_ep, .handshake, .ep0_tx_armed, .ep1_tx_armed, .ep1_rx_enable);

//--- verification/tb.sv
// Self-checking bench for the endpoint control block.
`timescale 1ns/1ps
`include "usbepc_cfg.svh"
module tb;
    logic        ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic        hreadyout, hresp, tog = 1'b0, en0 = 1'b0, en1 = 1'b0, a0, a1, rxe, oin;
    logic [8:0]  ev = 9'h0, e;
    logic        out_token, in_token;
    logic [3:0]  token_ep, tep;
    logic [9:0]  adr [4] = '{`USBEPC_ADDR_EP0TX, `USBEPC_ADDR_EP1RX, `USBEPC_ADDR_EP1TX, 10'h2d0};
    usbepc_pkg::usbepc_hs_e handshake;
    integer      miscompares = 0, samples_checked = 0, seed = 32'h3fe0fd96, i;
    int          m0arm = 0, m0st = 0, m1en = 0, m1rs = 0, m1tog = 0, m1arm = 0, m1ts = 0;
    always #12.5 ref_clk = ~ref_clk;
    usbepc_host_model i_usbepc_host_model (.ref_clk, .out_token, .in_token, .token_ep);
    usbepc_top i_usbepc_top (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(`USBEPC_HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .bus_reset(ev[8]), .setup_rcvd(ev[0]), .clr_halt_ep1(ev[1]), .set_halt_ep0(ev[2]),
        .set_halt_ep1_rx(ev[3]), .set_halt_ep1_tx(ev[4]), .ep0_tx_done(ev[5]),
        .ep1_tx_done(ev[6]), .ep1_rx_data(ev[7]), .ep0_tx_enabled(en0), .ep1_tx_enabled(en1),
        .ep1_rx_toggle(tog), .out_token, .in_token, .token_ep, .handshake,
        .ep0_tx_armed(a0), .ep1_tx_armed(a1), .ep1_rx_enable(rxe));
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic chk_hs(input usbepc_pkg::usbepc_hs_e g, input logic [1:0] x);
        samples_checked++;
        if (g !== x) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Processor writes land first, engine events afterwards, so hardware wins.
    task automatic model(input logic w, input logic [9:0] a, input logic [7:0] d);
        if (w && a == adr[0] && d[4]) m0arm = 1;
        if (w && a == adr[0] && d[2]) m0st = 1;
        if (w && a == adr[1] && d[2]) m1rs = 1;
        if (w && a == adr[1]) m1en = d[0];
        if (w && a == adr[2] && d[4]) m1arm = 1;
        if (w && a == adr[2] && d[2]) m1ts = 1;
        if (e[0] | e[8]) m0st = 0;
        if (e[1] | e[8]) m1rs = 0;
        if (e[1] | e[8]) m1ts = 0;
        if (e[2]) m0st = 1;
        if (e[3]) m1rs = 1;
        if (e[4]) m1ts = 1;
        if (e[5] | e[8]) m0arm = 0;
        if (e[6] | e[8]) m1arm = 0;
        if (e[7]) m1tog = tog;
        if (e[8]) m1en = 0;
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        logic [31:0] hi;
        hi = $random(seed);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= `USBEPC_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {hi[21:0], a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        ev <= e;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
        ev <= 9'h0;
        model(w, a, d[7:0]);
    endtask
    function automatic logic [31:0] exp_rd(input logic [9:0] a);
        exp_rd = 32'h0;
        if (a == adr[0]) exp_rd = {27'h0, m0arm[0], 1'b0, m0st[0], 1'b0, en0};
        if (a == adr[1]) exp_rd = {28'h0, m1tog[0], m1rs[0], 1'b0, m1en[0]};
        if (a == adr[2]) exp_rd = {27'h0, m1arm[0], 1'b0, m1ts[0], 1'b0, en1};
    endfunction
    function automatic logic [1:0] exp_hs(input logic is_in, input logic [3:0] ep);
        exp_hs = 2'h0;
        if (ep == 4'h0) exp_hs = is_in ? (m0st ? 2'h2 : 2'h0) : (m0arm ? 2'h1 : 2'h0);
        if (ep == 4'h1 && is_in) exp_hs = m1ts ? 2'h2 : 2'h0;
        if (ep == 4'h1 && !is_in) exp_hs = m1rs ? 2'h2 : ((m1arm || !m1en) ? 2'h1 : 2'h0);
    endfunction
    task automatic chkall();
        e = 9'h0;
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, adr[k], 32'h0);
            chk_reg(r, exp_rd(adr[k]));
        end
        chk_reg({29'h0, a0, a1, rxe}, {29'h0, m0arm[0], m1arm[0], m1en[0]});
        for (int k = 0; k < 2; k++) begin
            oin = $random(seed);
            tep = $unsigned($random(seed)) % 3;
            i_usbepc_host_model.send(oin, tep);
            #1 chk_hs(handshake, exp_hs(oin, tep));
        end
    endtask
    initial begin
        #500000;
        miscompares++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        chkall();
        e = 9'h0;
        for (int j = 0; j < 2; j++) begin
            for (int k = 0; k < 3; k++) bus(1'b1, adr[k], {32{j == 0}});
            chkall();
        end
        $display("test fixed patterns done");
        for (i = 0; i < 60; i++) begin
            @(posedge ref_clk);
            en0 <= $random(seed);
            en1 <= $random(seed);
            tog <= $random(seed);
            e = {i % 10 == 9, 8'($random(seed))};
            bus(1'b1, adr[$unsigned($random(seed)) % 4], $random(seed));
            chkall();
        end
        $display("test random traffic done");
        conclude();
    end
endmodule
